// ===== verilog/swig_status_gen.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module swig_status_gen
    import swig_pkg::*;
(
    input  wire logic               ref_clk_i,        // 100 MHz clock
    input  wire logic               rstn_i,           // Async reset, low
    // Sweep and processor events
    input  wire logic               gate_open_i,      // Window opens, pulse
    input  wire logic               gate_close_i,     // Window closes, pulse
    input  wire logic               reply_done_i,     // Replies all handed
    input  wire logic [1:0]         state_sel_i,      // Front-panel selector
    // Run parameters
    input  wire logic [RANGE_W-1:0] range_code_i,     // Range code
    input  wire logic [RATE_W-1:0]  pulse_rate_i,     // Binary pulse rate
    input  wire logic [DIGIT_W-1:0] upper_bcd_digit_i, // Divisor tens
    input  wire logic [DIGIT_W-1:0] lower_bcd_digit_i, // Divisor units
    // Performance monitor
    input  wire logic               perf_monitor_valid_i, // Data strobe
    input  wire logic [PM_ID_W-1:0] perf_monitor_id_i,    // Data kind
    input  wire logic [PM_VAL_W-1:0] perf_monitor_data_i, // Data value
    input  wire logic [ERR1_W-1:0]  fault_first_i,    // Error bits A..H
    input  wire logic [ERR2_W-1:0]  fault_second_i,   // Error bits I..N
    // Host interrupt interface
    output logic                    irq_req_o,        // Interrupt request
    output logic [WORD_W-1:0]       status_word_o,    // Status word
    input  wire logic               host_ack_i,       // Word accepted
    output logic                    reply_enable_o,   // Replies may pass
    // Register port
    input  wire logic [ADDR_W-1:0]  reg_addr_i,       // Byte address
    input  wire logic [31:0]        reg_wdata_i,      // Write data
    input  wire logic               reg_wr_i,         // Write strobe
    input  wire logic               reg_rd_i,         // Read strobe
    output logic [31:0]             reg_rdata_o       // Read data
);

    //==========================================================
    // Declarations
    swig_state_t          state_reg;
    swig_state_t          state_next;
    logic [1:0]           ctrl_reg;
    logic                 run_reg;
    logic                 internal_reg;
    logic                 gate_open_reg;
    logic                 pend_gate_reg;
    logic                 pend_merge_reg;
    logic                 pend_standby_reg;
    logic                 pend_run_reg;
    logic                 pm_valid_reg;
    logic [FIELD_W-1:0]   pm_word_reg;
    logic [3:0]           flags_reg;
    logic [3:0]           flags_next;
    logic                 run_sel_reg;
    logic [15:0]          count_reg;
    logic [31:0]          rdata_reg;
    logic                 sel_run;
    logic                 sel_internal;
    logic                 enter_standby;
    logic                 enter_run;
    logic                 take_standby;
    logic                 take_run;
    logic                 take_gate;
    logic                 issue;
    logic                 done;
    logic                 flush;
    logic [PM_VAL_W-1:0]  pm_value;
    logic [FIELD_W-1:0]   field;

    //==========================================================
    // Selector decode and transitions
    assign sel_run       = (state_sel_i == SEL_INTERNAL) ||
                           (state_sel_i == SEL_EXTERNAL);
    assign sel_internal  = (state_sel_i == SEL_INTERNAL);
    assign enter_standby = run_reg && (state_sel_i == SEL_STANDBY);
    assign enter_run     = !run_reg && sel_run;

    // Run state and mode, standby after reset
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg      <= 1'b0;
            internal_reg <= 1'b0;
        end else begin
            if (enter_standby) begin
                run_reg <= 1'b0;
            end else if (enter_run) begin
                run_reg <= 1'b1;
            end
            if (sel_run) begin
                internal_reg <= sel_internal;
            end
        end
    end

    // No replies pass in standby
    assign reply_enable_o = run_reg;

    //==========================================================
    // Listening window tracking
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gate_open_reg <= 1'b0;
        end else if (gate_open_i) begin
            gate_open_reg <= 1'b1;
        end else if (gate_close_i) begin
            gate_open_reg <= 1'b0;
        end
    end

    //==========================================================
    // Monitor capture; error words take fault bits
    always_comb begin
        pm_value = perf_monitor_data_i;
        if (perf_monitor_id_i == PM_ID_ERR1) begin
            pm_value = fault_first_i;
        end else if (perf_monitor_id_i == PM_ID_ERR2) begin
            pm_value = {2'b00, fault_second_i};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pm_word_reg <= 12'h000;
        end else if (perf_monitor_valid_i) begin
            pm_word_reg <= {perf_monitor_id_i, pm_value};
        end
    end

    // Validity flag; a fresh strobe wins
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pm_valid_reg <= 1'b0;
        end else if (perf_monitor_valid_i) begin
            pm_valid_reg <= 1'b1;
        end else if (take_gate || flush) begin
            pm_valid_reg <= 1'b0;
        end
    end

    //==========================================================
    // Issue priority: standby, run, gate
    assign flush        = reg_wr_i && (reg_addr_i == REG_CTRL) &&
                          reg_wdata_i[CTRL_FLUSH];
    assign issue        = (state_reg == SWIG_IDLE) && ctrl_reg[CTRL_EN];
    assign take_standby = issue && pend_standby_reg;
    assign take_run     = issue && !pend_standby_reg && pend_run_reg;
    assign take_gate    = issue && !pend_standby_reg && !pend_run_reg &&
                          pend_gate_reg && reply_done_i;
    assign done         = (state_reg == SWIG_REQ) && host_ack_i;

    //==========================================================
    // Pending causes; set wins over clear
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_gate_reg <= 1'b0;
        end else if (gate_close_i) begin
            pend_gate_reg <= 1'b1;
        end else if (take_gate || flush) begin
            pend_gate_reg <= 1'b0;
        end
    end

    // Standby during an open window rides on the gate word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_merge_reg <= 1'b0;
        end else if (enter_standby && (gate_open_reg || gate_open_i) &&
                     !gate_close_i) begin
            pend_merge_reg <= 1'b1;
        end else if (take_gate || flush) begin
            pend_merge_reg <= 1'b0;
        end
    end

    // Standby outside the window gets its own word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_standby_reg <= 1'b0;
        end else if (enter_standby &&
                     !((gate_open_reg || gate_open_i) && !gate_close_i)) begin
            pend_standby_reg <= 1'b1;
        end else if (take_standby || flush) begin
            pend_standby_reg <= 1'b0;
        end
    end

    // Run entry
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_run_reg <= 1'b0;
        end else if (enter_run) begin
            pend_run_reg <= 1'b1;
        end else if (take_run || flush) begin
            pend_run_reg <= 1'b0;
        end
    end

    //==========================================================
    // Flag nibble of the word about to be issued
    always_comb begin
        flags_next = 4'h0;
        if (take_standby) begin
            flags_next[FLAG_STANDBY-12] = 1'b1;
        end else if (take_run) begin
            flags_next[FLAG_RUN-12] = 1'b1;
            flags_next[FLAG_AUX-12] = !internal_reg;
        end else if (take_gate) begin
            flags_next[FLAG_GATE-12]    = 1'b1;
            flags_next[FLAG_STANDBY-12] = pend_merge_reg;
            flags_next[FLAG_AUX-12]     = pm_valid_reg;
        end
    end

    // Flags and mux steering held for the whole word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_reg   <= 4'h0;
            run_sel_reg <= 1'b0;
        end else if (state_reg == SWIG_IDLE) begin
            flags_reg   <= flags_next;
            run_sel_reg <= take_run;
        end
    end

    //==========================================================
    // Sequencer: pick, latch, request until ack
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SWIG_IDLE: begin
                if (take_standby || take_run || take_gate) begin
                    state_next = SWIG_LOAD;
                end
            end
            SWIG_LOAD: begin
                state_next = SWIG_REQ;
            end
            SWIG_REQ: begin
                if (host_ack_i) begin
                    state_next = SWIG_IDLE;
                end
            end
            default: begin
                state_next = SWIG_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= SWIG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    //==========================================================
    // Data field muxes and latches
    swig_data_mux u_data_mux (
        .ref_clk_i         (ref_clk_i),
        .rstn_i            (rstn_i),
        .internal_i        (internal_reg),
        .run_pulse_i       (run_sel_reg),
        .load_i            (state_reg == SWIG_LOAD),
        .range_i           (range_code_i),
        .pulse_rate_i      (pulse_rate_i),
        .upper_bcd_digit_i (upper_bcd_digit_i),
        .lower_bcd_digit_i (lower_bcd_digit_i),
        .pm_i              (pm_word_reg),
        .field_o           (field)
    );

    // Word and request stay put until the host takes the word
    assign irq_req_o     = (state_reg == SWIG_REQ);
    assign status_word_o = {flags_reg, field};

    //==========================================================
    // Count of accepted words
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= 16'h0000;
        end else if (done) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    //==========================================================
    // Control register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_wr_i && (reg_addr_i == REG_CTRL)) begin
            ctrl_reg <= {1'b0, reg_wdata_i[CTRL_EN]};
        end
    end

    //==========================================================
    // Read data one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL:   rdata_reg <= {30'h0, ctrl_reg};
                REG_STATUS: rdata_reg <= {21'h0, state_reg, irq_req_o,
                                          run_reg, internal_reg,
                                          gate_open_reg, pm_valid_reg,
                                          pend_merge_reg, pend_standby_reg,
                                          pend_run_reg, pend_gate_reg};
                REG_WORD:   rdata_reg <= {16'h0, status_word_o};
                REG_COUNT:  rdata_reg <= {16'h0, count_reg};
                default:    rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule : swig_status_gen

// ===== verilog/swig_pkg.sv
//==============================================================
// Function
// - Interrupt causes: gate closed, standby entry, run entry.
// - Bits 15..12 are gate, standby, run and monitor/mode flags.
// - Gate word waits until replies are processed and handed over.
// - Gate word may also carry standby and monitor flags.
// - Standby during an open window merges into the gate word.
// - Monitor flag only when the field holds valid monitor data.
// - Monitor data is latched for the next word.
// - Standby word when selector leaves a run setting.
// - Standby keeps gate words but blocks replies.
// - Run word when selector leaves standby.
// - First mux pair picks pulse rate or BCD divisor by mode line.
// - Run pulse muxes pick parameters or range versus monitor data.
// - Three latches hold the mux outputs as the field.
// - Run parameters only in the run word, monitor data otherwise.
// - Monitor word: flags 1x01, id in 11..8, value in 7..0.
// - First error word holds eight pass/fail bits in 7..0.
// - Second error word holds six pass/fail bits in 5..0.
// - Error bit zero means normal, one means error.
// - Internal run word: flags 0010, range 11..9, binary rate 8..0.
// - External run word: flags 0011, range 11..9, two BCD digits low.
// - Range codes 010,001,000,110,101,100 mean 5,10,20,50,100,200 nmi.
//==============================================================
package swig_pkg;

    //==========================================================
    // Status word layout
    localparam int          WORD_W       = 16;
    localparam int          FIELD_W      = 12;
    localparam int          FLAG_GATE    = 15;
    localparam int          FLAG_STANDBY = 14;
    localparam int          FLAG_RUN     = 13;
    localparam int          FLAG_AUX     = 12;
    localparam int          RANGE_W      = 3;
    localparam int          RATE_W       = 9;
    localparam int          DIGIT_W      = 4;
    localparam int          PM_ID_W      = 4;
    localparam int          PM_VAL_W     = 8;
    localparam int          ERR1_W       = 8;
    localparam int          ERR2_W       = 6;

    //==========================================================
    // Error word identifiers
    localparam logic [3:0]  PM_ID_ERR1   = 4'ha;
    localparam logic [3:0]  PM_ID_ERR2   = 4'hb;

    //==========================================================
    // Range codes in nautical miles
    localparam logic [2:0]  RANGE_5      = 3'h2;
    localparam logic [2:0]  RANGE_10     = 3'h1;
    localparam logic [2:0]  RANGE_20     = 3'h0;
    localparam logic [2:0]  RANGE_50     = 3'h6;
    localparam logic [2:0]  RANGE_100    = 3'h5;
    localparam logic [2:0]  RANGE_200    = 3'h4;

    //==========================================================
    // Selector settings
    localparam logic [1:0]  SEL_STANDBY  = 2'h0;
    localparam logic [1:0]  SEL_INTERNAL = 2'h1;
    localparam logic [1:0]  SEL_EXTERNAL = 2'h2;

    //==========================================================
    // Register map and reset values
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_WORD     = 4'h8;
    localparam logic [3:0]  REG_COUNT    = 4'hc;
    localparam logic [1:0]  CTRL_RESET   = 2'h1;
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_FLUSH   = 1;

    //==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SWIG_IDLE = 2'b00,
        SWIG_LOAD = 2'b01,
        SWIG_REQ  = 2'b10
    } swig_state_t;

endpackage : swig_pkg

// ===== verilog/swig_data_mux.sv
`timescale 1ns/1ps
module swig_data_mux
    import swig_pkg::*;
(
    input  wire logic               ref_clk_i,     // System clock
    input  wire logic               rstn_i,        // Async reset, low
    input  wire logic               internal_i,    // Internal mode line
    input  wire logic               run_pulse_i,   // Run word select
    input  wire logic               load_i,        // Latch strobe
    input  wire logic [RANGE_W-1:0] range_i,       // Range code
    input  wire logic [RATE_W-1:0]  pulse_rate_i,  // Binary pulse rate
    input  wire logic [DIGIT_W-1:0] upper_bcd_digit_i, // Divisor tens
    input  wire logic [DIGIT_W-1:0] lower_bcd_digit_i, // Divisor units
    input  wire logic [FIELD_W-1:0] pm_i,          // Monitor id and value
    output logic      [FIELD_W-1:0] field_o        // Latched data field
);

    //==========================================================
    // First pair: rate or divisor
    logic       mode_hi;
    logic [7:0] mode_lo;
    assign mode_hi = internal_i ? pulse_rate_i[8] : 1'b0;
    assign mode_lo = internal_i ? pulse_rate_i[7:0]
                   : {upper_bcd_digit_i, lower_bcd_digit_i};

    //==========================================================
    // Second pair and third mux, steered by the run pulse
    logic [2:0] mux_top;
    logic       mux_mid;
    logic [7:0] mux_low;
    assign mux_top = run_pulse_i ? range_i : pm_i[11:9];
    assign mux_mid = run_pulse_i ? mode_hi : pm_i[8];
    assign mux_low = run_pulse_i ? mode_lo : pm_i[7:0];

    //==========================================================
    // Three latching buffers
    logic [2:0] buf_top_reg;
    logic       buf_mid_reg;
    logic [7:0] buf_low_reg;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_top_reg <= 3'h0;
            buf_mid_reg <= 1'b0;
            buf_low_reg <= 8'h00;
        end else if (load_i) begin
            buf_top_reg <= mux_top;
            buf_mid_reg <= mux_mid;
            buf_low_reg <= mux_low;
        end
    end

    assign field_o = {buf_top_reg, buf_mid_reg, buf_low_reg};

endmodule : swig_data_mux

// ===== dv/swig_status_gen_properties.sv
`timescale 1ns/1ps
// ==============================
// Host interrupt port checks
module swig_status_gen_checker
    import swig_pkg::*;
(
    input wire logic               ref_clk_i,         // Clock
    input wire logic               rstn_i,            // Reset
    input wire logic               reply_done_i,      // Replies done
    input wire logic [1:0]         state_sel_i,       // Selector
    input wire logic [RANGE_W-1:0] range_code_i,      // Range
    input wire logic [RATE_W-1:0]  pulse_rate_i,      // Rate
    input wire logic [DIGIT_W-1:0] upper_bcd_digit_i, // Tens
    input wire logic [DIGIT_W-1:0] lower_bcd_digit_i, // Units
    input wire logic               host_ack_i,        // Accept
    input wire logic               irq_req_o,         // Request
    input wire logic [WORD_W-1:0]  status_word_o      // Word
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // New word, new run word, replies still outstanding
    sequence s_new; $rose(irq_req_o); endsequence
    sequence s_run; s_new ##0 status_word_o[15:13] == 3'b001; endsequence
    sequence s_dry; !reply_done_i [*4]; endsequence
    a_word_holds: assert property (irq_req_o && !host_ack_i
        |=> irq_req_o && $stable(status_word_o)) else $error("word moved");
    a_ack_release: assert property (irq_req_o && host_ack_i
        |=> !irq_req_o [*2]) else $error("request kept after ack");
    a_flags_legal: assert property (s_new |->
        status_word_o[15:12] inside {4'h8, 4'h9, 4'hc, 4'hd, 4'h4, 4'h2,
        4'h3}) else $error("bad flag set");
    a_gate_waits: assert property (s_dry |->
        !($rose(irq_req_o) && status_word_o[15])) else $error("gate early");
    a_monitor_id: assert property (s_new ##0 status_word_o[15]
        && status_word_o[12] |-> status_word_o[11:8] inside {[4'h1:4'hb]})
        else $error("bad monitor id");
    a_int_field: assert property (s_run ##0 !status_word_o[12] |->
        status_word_o[11:0] == {range_code_i, pulse_rate_i})
        else $error("internal run field");
    a_ext_field: assert property (s_run ##0 status_word_o[12] |->
        {status_word_o[11:9], status_word_o[7:0]} == {range_code_i,
        upper_bcd_digit_i, lower_bcd_digit_i}) else $error("external field");
    a_mode_flag: assert property (s_run |-> status_word_o[12] ==
        (state_sel_i == SEL_EXTERNAL)) else $error("mode flag");
endmodule : swig_status_gen_checker
bind swig_status_gen swig_status_gen_checker chk_u (
    .ref_clk_i, .rstn_i, .reply_done_i, .state_sel_i, .range_code_i,
    .pulse_rate_i, .upper_bcd_digit_i, .lower_bcd_digit_i, .host_ack_i,
    .irq_req_o, .status_word_o
);

// ===== dv/swig_host_model.sv
`timescale 1ns/1ps
// ==============================
// Host side of the interrupt link
module swig_host_model #(
    parameter int MIN_GATES = 4  // Gate words before a run is honoured
) (
    input  wire logic        ref_clk_i,  // Clock
    input  wire logic        rstn_i,     // Reset
    input  wire logic        irq_req_i,  // Request
    input  wire logic [15:0] word_i,     // Status word
    input  wire logic [7:0]  delay_i,    // Wait before accepting
    output logic             host_ack_o, // Accept pulse
    output logic [7:0]       taken_o,    // Words accepted
    output logic             standby_o   // Host idled
);
    logic [7:0] wait_reg;
    logic [7:0] gates_reg;
    // Accept each request once after the wait
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_ack_o <= 1'b0;
            wait_reg   <= 8'h0;
        end else begin
            host_ack_o <= irq_req_i && !host_ack_o && wait_reg >= delay_i;
            wait_reg   <= irq_req_i ? wait_reg + 8'h1 : 8'h0;
        end
    end
    // Idle on any word with the standby flag; leave on a run word after enough gate words
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {taken_o, gates_reg, standby_o} <= 17'h1;
        end else if (host_ack_o) begin
            taken_o   <= taken_o + 8'h1;
            gates_reg <= word_i[14] ? 8'h0 : gates_reg + {7'h0, word_i[15]};
            standby_o <= word_i[14] | (standby_o & ~(word_i[13]
                         & (gates_reg >= MIN_GATES)));
        end
    end
endmodule : swig_host_model

// ===== dv/swig_status_gen_tb_top.sv
`timescale 1ns/1ps
// ==============================
// Status interrupt bench
module swig_status_gen_tb_top
    import swig_pkg::*;
;
    logic        ref_clk, rstn, gate_open, gate_close, reply_done, pm_valid;
    logic        host_ack, irq_req, reply_en, reg_wr, reg_rd, host_standby;
    logic [1:0]  state_sel;
    logic [2:0]  range_code;
    logic [8:0]  pulse_rate;
    logic [3:0]  upper_digit, lower_digit, pm_id, reg_addr;
    logic [7:0]  pm_data, fault_first, ack_delay, taken;
    logic [5:0]  fault_second;
    logic [15:0] word;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  rng [6] = '{RANGE_5, RANGE_10, RANGE_20, RANGE_50,
                             RANGE_100, RANGE_200};
    int          num_errors, num_checks;
    swig_status_gen dut_u (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .gate_open_i(gate_open),
        .gate_close_i(gate_close), .reply_done_i(reply_done),
        .state_sel_i(state_sel), .range_code_i(range_code),
        .pulse_rate_i(pulse_rate), .upper_bcd_digit_i(upper_digit),
        .lower_bcd_digit_i(lower_digit), .perf_monitor_valid_i(pm_valid),
        .perf_monitor_id_i(pm_id), .perf_monitor_data_i(pm_data),
        .fault_first_i(fault_first), .fault_second_i(fault_second),
        .irq_req_o(irq_req), .status_word_o(word), .host_ack_i(host_ack),
        .reply_enable_o(reply_en), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata));
    swig_host_model host_u (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .irq_req_i(irq_req),
        .word_i(word), .delay_i(ack_delay), .host_ack_o(host_ack),
        .taken_o(taken), .standby_o(host_standby));
    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // Await a request, compare the word, await release
    task automatic expect_word(input string n, input logic [15:0] e, m);
        @(negedge ref_clk);
        repeat (300) if (irq_req !== 1'b1) @(negedge ref_clk);
        check("irq", irq_req, 1'b1);
        check(n, word & m, e & m);
        repeat (300) if (irq_req === 1'b1) @(negedge ref_clk);
    endtask : expect_word
    // Sweep: open, monitor strobe and selector, close
    task automatic sweep(input logic pm, input logic [3:0] id,
                         input logic [1:0] sel);
        @(posedge ref_clk) gate_open <= 1'b1;
        @(posedge ref_clk) {gate_open, pm_valid, pm_id, state_sel}
            <= {1'b0, pm, id, sel};
        @(posedge ref_clk) {pm_valid, gate_close} <= 2'b01;
        @(posedge ref_clk) gate_close <= 1'b0;
    endtask : sweep
    task automatic reg_op(input logic wr, input logic [3:0] a,
                          input logic [31:0] d);
        @(posedge ref_clk) {reg_wr, reg_rd, reg_addr, reg_wdata}
            <= {wr, !wr, a, d};
        @(posedge ref_clk) {reg_wr, reg_rd} <= 2'b00;
        @(negedge ref_clk);
    endtask : reg_op
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rstn = 1'b0;
        {gate_open, gate_close, pm_valid, reg_wr, reg_rd} = 5'h0;
        {reply_done, state_sel, range_code} = {1'b1, SEL_INTERNAL, RANGE_50};
        {pulse_rate, upper_digit, lower_digit} = 17'h1a537;
        {pm_id, pm_data, fault_first, fault_second} = 26'hd72065;
        {ack_delay, reg_addr, reg_wdata} = 44'h0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        expect_word("reset run", {4'h2, RANGE_50, 9'h1a5}, 16'hffff);
        foreach (rng[i]) begin
            @(posedge ref_clk) state_sel <= SEL_STANDBY;
            expect_word("standby", 16'h4000, 16'hf000);
            @(posedge ref_clk) range_code <= rng[i];
            @(posedge ref_clk) state_sel <= i[0] ? SEL_EXTERNAL : SEL_INTERNAL;
            expect_word("run", i[0] ? {4'h3, rng[i], 1'b0, 8'h37}
                : {4'h2, rng[i], 9'h1a5}, i[0] ? 16'hfeff : 16'hffff);
        end
        sweep(1'b1, 4'h3, SEL_EXTERNAL);
        expect_word("monitor", 16'h935c, 16'hffff);
        sweep(1'b1, PM_ID_ERR1, SEL_EXTERNAL);
        expect_word("error one", 16'h9a81, 16'hffff);
        sweep(1'b1, PM_ID_ERR2, SEL_EXTERNAL);
        expect_word("error two", 16'h9b25, 16'hff3f);
        @(posedge ref_clk) {ack_delay, reply_done} <= {8'h1e, 1'b0};
        sweep(1'b0, 4'h3, SEL_EXTERNAL);
        repeat (20) @(negedge ref_clk);
        check("early gate", irq_req, 1'b0);
        @(posedge ref_clk) reply_done <= 1'b1;
        expect_word("late gate", 16'h8000, 16'hf000);
        sweep(1'b0, 4'h3, SEL_EXTERNAL);
        sweep(1'b0, 4'h3, SEL_EXTERNAL);
        expect_word("gate one", 16'h8000, 16'hf000);
        expect_word("gate two", 16'h8000, 16'hf000);
        sweep(1'b0, 4'h3, SEL_STANDBY);
        expect_word("gate standby", 16'hc000, 16'hf000);
        sweep(1'b0, 4'h3, SEL_STANDBY);
        expect_word("standby sweep", 16'h8000, 16'hf000);
        check("reply gate", reply_en, 1'b0);
        reg_op(1'b1, REG_CTRL, 32'h0);
        @(posedge ref_clk) state_sel <= SEL_INTERNAL;
        repeat (20) @(negedge ref_clk);
        check("held run", irq_req, 1'b0);
        reg_op(1'b1, REG_CTRL, 32'h1);
        expect_word("enabled run", {4'h2, RANGE_200, 9'h1a5}, 16'hffff);
        check("host idle", host_standby, 1'b1);
        reg_op(1'b0, REG_CTRL, 32'h0);
        check("ctrl", reg_rdata, 32'h1);
        reg_op(1'b0, 4'h2, 32'h0);
        check("unmapped", reg_rdata, 32'h0);
        reg_op(1'b0, REG_COUNT, 32'h0);
        check("count", reg_rdata, {24'h0, taken});
        give_verdict();
    end
endmodule : swig_status_gen_tb_top
